// ---- phy_led_pkg.sv ----
// Constants and carrier types for the indicator, strap and interrupt block.
`default_nettype none
package phy_led_pkg;
   // Core clock rate and the timing figures derived from it.
   localparam int CLK_HZ = 20_000_000;
   localparam int RESET_SETTLE_US = 1000;
   localparam int RESET_SETTLE_CYCLES =
      (CLK_HZ / 1_000_000) * RESET_SETTLE_US;
   localparam int BLINK_SLOW_HZ = 10;
   localparam int BLINK_FAST_HZ = 20;
   localparam int BLINK_SLOW_HALF_CYCLES = CLK_HZ / (2 * BLINK_SLOW_HZ);
   localparam int BLINK_FAST_HALF_CYCLES = CLK_HZ / (2 * BLINK_FAST_HZ);
   localparam int CNT_W = 21;

   // Register indices; the byte address is four times the index.
   localparam logic [5:0] IDX_STRAP = 6'h14;
   localparam logic [5:0] IDX_INT_STATUS = 6'h17;
   localparam logic [5:0] IDX_INT_ENABLE = 6'h18;
   localparam logic [5:0] IDX_IND_CONFIG = 6'h1b;
   localparam int REG_W = 16;
   localparam logic [15:0] REG_RESET = 16'h0000;

   // Strap register bit positions.
   localparam int STRAP_SPEED10_BIT = 7;
   localparam int STRAP_ACTIVITY_BIT = 6;
   localparam int STRAP_LINK_BIT = 5;
   localparam int STRAP_DUPLEX_BIT = 4;
   localparam int STRAP_SPEED100_BIT = 3;

   // Indicator pin positions in the pin vectors.
   localparam int LED_SPEED100 = 0;
   localparam int LED_DUPLEX = 1;
   localparam int LED_LINK = 2;
   localparam int LED_ACTIVITY = 3;
   localparam int LED_SPEED10 = 4;
   localparam int LED_N = 5;

   // Configuration and interrupt bit positions.
   localparam int CFG_LINK_BLINK_OFF_BIT = 9;
   localparam int INT_LINK_BIT = 0;
   localparam int INT_SPEED_BIT = 1;
   localparam int INT_DUPLEX_BIT = 2;
   localparam int INT_COLLISION_BIT = 3;
   localparam int INT_N = 4;

   // Status reported by the transceiver core on the same clock.
   typedef struct packed {
      logic speed_100;
      logic link_good;
      logic full_duplex;
      logic collision;
      logic rx_active;
      logic tx_active;
   } phy_status_t;

   // Output half of the indicator pins.
   typedef struct packed {
      logic [4:0] value;
      logic [4:0] enable;
   } led_drive_t;

   typedef enum logic [1:0] {
      RST_HOLD,
      RST_SETTLE,
      RST_WAIT_MDC,
      RST_DONE
   } reset_state_t;
endpackage
`default_nettype wire

// ---- phy_led_strap_and_mgmt_interrupt.sv ----
// Indicator drive, strap capture, reset completion and management interrupt.
//
// Contract
// [R1] Controller supplies the management clock at no more than 2.5 MHz.
// [R2] Reset completes only after a management clock transition is seen.
// [R3] Interrupt output active while an enabled status bit has changed.
// [R4] Reading interrupt status clears it and releases the output; the block instead drives the line low (mgmt_int_oe high).
// [R5] Board supplies the reference clock from crystal or oscillator.
// [R6] Speed-10 indicator steadily on while the link runs at 10 Mb/s.
// [R7] Speed-10 pin pull level latched into strap bit 7 during reset.
// [R8] Activity indicator blinks at 10 Hz during receive or transmit.
// [R9] Activity pin pull level latched into strap bit 6 during reset.
// [R10] Link indicator on with good link, blinks on activity unless bit 9 set.
// [R11] Link pin pull level latched into strap bit 5 during reset.
// [R12] Duplex indicator steadily on in full duplex.
// [R13] Duplex indicator blinks at 20 Hz on collision in half duplex.
// [R14] Duplex pin pull level latched into strap bit 4 during reset.
// [R15] Speed-100 indicator steadily on while the link runs at 100 Mb/s.
// [R16] Speed-100 pin pull level latched into strap bit 3 during reset.
// [R17] Reset input is held low at least 1 ms by its driver.
// [R18] Reset-done output high only once reset completes, low before.
// [R19] Pins undriven in reset; each lights at the inverse of its strap.
// [R20] Blink rates come from counters dividing the core clock.
`timescale 1ns/10ps
`default_nettype none

module phy_led_strap_and_mgmt_interrupt
   import phy_led_pkg::*;
#(
   parameter int SETTLE_CYCLES = RESET_SETTLE_CYCLES,
   parameter int SLOW_HALF_CYCLES = BLINK_SLOW_HALF_CYCLES,
   parameter int FAST_HALF_CYCLES = BLINK_FAST_HALF_CYCLES
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire phy_status_t phy_status,
   input wire logic mdc,
   input wire logic [4:0] led_in,
   output led_drive_t led_drive,
   output logic mgmt_int_out,
   output logic mgmt_int_oe,
   output logic reset_done
);

   // Reset sequencer state and its timer.
   reset_state_t rst_state_reg;
   reset_state_t rst_state_next;
   logic [CNT_W-1:0] settle_cnt_reg;
   logic [CNT_W-1:0] settle_cnt_next;
   logic mdc_seen_reg;
   logic mdc_seen_next;

   // Pin synchronisers.
   logic mdc_meta_reg;
   logic mdc_sync_reg;
   logic mdc_prev_reg;
   logic [2:0] mdc_fill_reg;
   logic [4:0] led_meta_reg;
   logic [4:0] led_sync_reg;

   // Software-visible registers and the internal interrupt pending flag.
   logic [REG_W-1:0] strap_latch_reg;
   logic [REG_W-1:0] strap_latch_next;
   logic [REG_W-1:0] interrupt_enable_reg;
   logic [REG_W-1:0] interrupt_enable_next;
   logic [REG_W-1:0] indicator_config_reg;
   logic [REG_W-1:0] indicator_config_next;
   logic [INT_N-1:0] interrupt_status_reg;
   logic [INT_N-1:0] interrupt_status_next;
   logic int_pending_reg;

   // Bus answer registers.
   logic ack_reg;
   logic [31:0] rd_data_reg;
   logic [31:0] rd_data_next;

   // Blink dividers and indicator drive.
   logic [CNT_W-1:0] slow_cnt_reg;
   logic [CNT_W-1:0] fast_cnt_reg;
   logic slow_phase_reg;
   logic fast_phase_reg;
   logic [4:0] led_lit;
   logic [4:0] led_value_reg;
   logic [4:0] led_value_next;
   logic [4:0] led_enable_reg;

   // Previous status snapshot for change detection.
   phy_status_t status_prev_reg;

   // Decoded strobes and helper wires.
   logic bus_take;
   logic bus_write;
   logic bus_read;
   logic [5:0] bus_idx;
   logic status_clear;
   logic [INT_N-1:0] int_events;
   logic mdc_edge;
   logic settle_over;
   logic is_done;
   logic any_activity;
   logic link_10;
   logic link_100;
   logic slow_wrap;
   logic fast_wrap;

   // Merges a bus write into a 16-bit register honouring the low lanes.
   function automatic logic [REG_W-1:0] merge_write(
      input logic [REG_W-1:0] old_val,
      input logic [31:0] data,
      input logic [3:0] sel
   );
      logic [REG_W-1:0] result;
      result = old_val;
      if (sel[0]) begin
         result[7:0] = data[7:0];
      end
      if (sel[1]) begin
         result[15:8] = data[15:8];
      end
      return result;
   endfunction

   // Bus decode: a request is taken once, in the cycle before ack rises.
   assign bus_take = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign bus_write = bus_take & wb_we_i;
   assign bus_read = bus_take & ~wb_we_i;
   assign bus_idx = wb_adr_i[7:2];
   assign status_clear = bus_read & (bus_idx == IDX_INT_STATUS); // R4

   // Read multiplexer; unmapped indices read as zero.
   always_comb begin
      rd_data_next = rd_data_reg;
      if (bus_read) begin
         unique case (bus_idx)
            IDX_STRAP: rd_data_next = {16'h0000, strap_latch_reg};
            IDX_INT_STATUS: rd_data_next = {28'h0000000, interrupt_status_reg};
            IDX_INT_ENABLE: rd_data_next = {16'h0000, interrupt_enable_reg};
            IDX_IND_CONFIG: rd_data_next = {16'h0000, indicator_config_reg};
            default: rd_data_next = 32'h00000000;
         endcase
      end
   end

   // Writable registers; the strap and status registers ignore writes.
   assign interrupt_enable_next =
      (bus_write && bus_idx == IDX_INT_ENABLE) ?
      merge_write(interrupt_enable_reg, wb_dat_i, wb_sel_i) :
      interrupt_enable_reg;
   assign indicator_config_next =
      (bus_write && bus_idx == IDX_IND_CONFIG) ?
      merge_write(indicator_config_reg, wb_dat_i, wb_sel_i) :
      indicator_config_reg;

   // Bus answer: ack follows one cycle after the request is seen.
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         ack_reg <= 1'b0;
         rd_data_reg <= 32'h00000000;
         interrupt_enable_reg <= REG_RESET;
         indicator_config_reg <= REG_RESET;
      end else begin
         ack_reg <= bus_take;
         rd_data_reg <= rd_data_next;
         interrupt_enable_reg <= interrupt_enable_next;
         indicator_config_reg <= indicator_config_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rd_data_reg;

   // The first stage of each synchroniser feeds only the second.
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         mdc_meta_reg <= 1'b0;
         mdc_sync_reg <= 1'b0;
         mdc_prev_reg <= 1'b0;
         mdc_fill_reg <= 3'h0;
         led_meta_reg <= 5'h00;
         led_sync_reg <= 5'h00;
      end else begin
         mdc_meta_reg <= mdc;
         mdc_sync_reg <= mdc_meta_reg;
         mdc_prev_reg <= mdc_sync_reg;
         mdc_fill_reg <= {mdc_fill_reg[1:0], 1'b1};
         led_meta_reg <= led_in;
         led_sync_reg <= led_meta_reg;
      end
   end

   // Either edge of the management clock counts as a transition.
   // Edges are ignored until the history has refilled after reset, or a
   // clock resting high would look like a transition and end reset early.
   assign mdc_edge = (mdc_sync_reg ^ mdc_prev_reg) & mdc_fill_reg[2]; // R2
   assign settle_over = (settle_cnt_reg == CNT_W'(SETTLE_CYCLES - 1));
   assign is_done = (rst_state_reg == RST_DONE);

   // Reset sequencer: hold one cycle, settle, then wait for the clock.
   // The first cycle after release is spent in hold, which fills only the first
   // pin synchroniser stage, so the earliest strap sample still reads reset zeros.
   always_comb begin
      rst_state_next = rst_state_reg;
      settle_cnt_next = settle_cnt_reg;
      mdc_seen_next = mdc_seen_reg | mdc_edge; // R2
      unique case (rst_state_reg)
         RST_HOLD: begin
            rst_state_next = RST_SETTLE;
            settle_cnt_next = '0;
         end
         RST_SETTLE: begin
            settle_cnt_next = settle_cnt_reg + CNT_W'(1);
            if (settle_over) begin
               rst_state_next = RST_WAIT_MDC;
            end
         end
         RST_WAIT_MDC: begin
            if (mdc_seen_next) begin
               rst_state_next = RST_DONE; // R2
            end
         end
         RST_DONE: begin
            rst_state_next = RST_DONE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rst_state_reg <= RST_HOLD;
         settle_cnt_reg <= '0;
         mdc_seen_reg <= 1'b0;
      end else begin
         rst_state_reg <= rst_state_next;
         settle_cnt_reg <= settle_cnt_next;
         mdc_seen_reg <= mdc_seen_next;
      end
   end

   assign reset_done = is_done; // R18

   // Straps follow the undriven pins until reset completes, then freeze.
   // Sampling continuously rather than once rides out slow pull edges.
   always_comb begin
      strap_latch_next = strap_latch_reg;
      if (rst_state_reg == RST_SETTLE || rst_state_reg == RST_WAIT_MDC) begin
         strap_latch_next[STRAP_SPEED10_BIT] = led_sync_reg[LED_SPEED10]; // R7
         strap_latch_next[STRAP_ACTIVITY_BIT] =
            led_sync_reg[LED_ACTIVITY]; // R9
         strap_latch_next[STRAP_LINK_BIT] = led_sync_reg[LED_LINK]; // R11
         strap_latch_next[STRAP_DUPLEX_BIT] = led_sync_reg[LED_DUPLEX]; // R14
         strap_latch_next[STRAP_SPEED100_BIT] =
            led_sync_reg[LED_SPEED100]; // R16
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         strap_latch_reg <= REG_RESET;
      end else begin
         strap_latch_reg <= strap_latch_next;
      end
   end

   // Blink dividers from the core clock; each phase toggles per half period.
   assign slow_wrap = (slow_cnt_reg == CNT_W'(SLOW_HALF_CYCLES - 1)); // R20
   assign fast_wrap = (fast_cnt_reg == CNT_W'(FAST_HALF_CYCLES - 1)); // R20

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         slow_cnt_reg <= '0;
         fast_cnt_reg <= '0;
         slow_phase_reg <= 1'b0;
         fast_phase_reg <= 1'b0;
      end else begin
         slow_cnt_reg <= slow_wrap ? '0 : slow_cnt_reg + CNT_W'(1);
         fast_cnt_reg <= fast_wrap ? '0 : fast_cnt_reg + CNT_W'(1);
         slow_phase_reg <= slow_phase_reg ^ slow_wrap;
         fast_phase_reg <= fast_phase_reg ^ fast_wrap;
      end
   end

   // Which indicators should be lit this cycle.
   assign any_activity = phy_status.rx_active | phy_status.tx_active;
   assign link_10 = phy_status.link_good & ~phy_status.speed_100;
   assign link_100 = phy_status.link_good & phy_status.speed_100;

   assign led_lit[LED_SPEED10] = link_10; // R6
   assign led_lit[LED_SPEED100] = link_100; // R15
   assign led_lit[LED_ACTIVITY] = any_activity & slow_phase_reg; // R8
   assign led_lit[LED_LINK] = phy_status.link_good &
      ~(any_activity & ~indicator_config_reg[CFG_LINK_BLINK_OFF_BIT] &
        ~slow_phase_reg); // R10
   assign led_lit[LED_DUPLEX] = phy_status.full_duplex |
      (phy_status.collision & fast_phase_reg); // R12 R13

   // The lit level is the inverse of the strap so either pull works.
   // Strap bits sit high in the register, so map them by position.
   assign led_value_next[LED_SPEED10] =
      led_lit[LED_SPEED10] ^ strap_latch_reg[STRAP_SPEED10_BIT]; // R19
   assign led_value_next[LED_ACTIVITY] =
      led_lit[LED_ACTIVITY] ^ strap_latch_reg[STRAP_ACTIVITY_BIT]; // R19
   assign led_value_next[LED_LINK] =
      led_lit[LED_LINK] ^ strap_latch_reg[STRAP_LINK_BIT]; // R19
   assign led_value_next[LED_DUPLEX] =
      led_lit[LED_DUPLEX] ^ strap_latch_reg[STRAP_DUPLEX_BIT]; // R19
   assign led_value_next[LED_SPEED100] =
      led_lit[LED_SPEED100] ^ strap_latch_reg[STRAP_SPEED100_BIT]; // R19

   // Pins are released until reset completes, so the pulls are readable.
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         led_value_reg <= 5'h00;
         led_enable_reg <= 5'h00;
      end else begin
         led_value_reg <= led_value_next;
         led_enable_reg <= {LED_N{is_done}}; // R19
      end
   end

   assign led_drive.value = led_value_reg;
   assign led_drive.enable = led_enable_reg;

   // Status change detection; idle until reset completes.
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         status_prev_reg <= '0;
      end else begin
         status_prev_reg <= phy_status;
      end
   end

   assign int_events[INT_LINK_BIT] = is_done &
      (phy_status.link_good ^ status_prev_reg.link_good); // R3
   assign int_events[INT_SPEED_BIT] = is_done &
      (phy_status.speed_100 ^ status_prev_reg.speed_100); // R3
   assign int_events[INT_DUPLEX_BIT] = is_done &
      (phy_status.full_duplex ^ status_prev_reg.full_duplex); // R3
   assign int_events[INT_COLLISION_BIT] = is_done &
      (phy_status.collision & ~status_prev_reg.collision); // R3

   // A new event in the clearing cycle survives the clear.
   assign interrupt_status_next =
      (interrupt_status_reg & {INT_N{~status_clear}}) | int_events; // R4

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         interrupt_status_reg <= '0;
         int_pending_reg <= 1'b0;
      end else begin
         interrupt_status_reg <= interrupt_status_next;
         int_pending_reg <= |(interrupt_status_next &
            interrupt_enable_reg[INT_N-1:0]); // R3
      end
   end

   // Active-high open-drain: hold the line low until an interrupt is due,
   // then let the board pull-up raise it.
   assign mgmt_int_out = 1'b0;
   assign mgmt_int_oe = ~int_pending_reg; // R3 R4

endmodule // phy_led_strap_and_mgmt_interrupt
`default_nettype wire

// ---- led_checker.sv ----
// Port-level assertions for the indicator, strap and interrupt block.
`timescale 1ns/10ps
`default_nettype none
module led_checker
   import phy_led_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire phy_status_t phy_status,
   input wire logic mdc,
   input wire logic [4:0] led_in,
   input wire led_drive_t led_drive,
   input wire logic mgmt_int_out,
   input wire logic mgmt_int_oe,
   input wire logic reset_done
);
   logic [3:0] en_reg;
   logic [4:0] strap_reg;
   logic mdc_q;
   logic mdc_seen;
   // Decoded bus requests, taken only while ack is low.
   wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire st_rd = take && !wb_we_i && wb_adr_i[7:2] == IDX_INT_STATUS;
   wire en_wr = take && wb_we_i && wb_sel_i[0] &&
      wb_adr_i[7:2] == IDX_INT_ENABLE;
   wire lit_ok = &led_drive.enable;
   // Shadow of the enable register and the pulls; pins are undriven
   // until done, so the read-back level is the strap itself.
   always_ff @(posedge core_clk) begin
      mdc_q <= mdc;
      if (!reset_n) begin
         en_reg <= 4'h0;
         mdc_seen <= 1'b0;
      end else begin
         if (mdc != mdc_q) mdc_seen <= 1'b1;
         if (en_wr) en_reg <= wb_dat_i[3:0];
      end
      if (!reset_done) strap_reg <= led_in;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   bus_ack_a: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack is not a one-cycle answer");
   done_hold_a: assert property ($rose(reset_n) |-> !reset_done [*8])
      else $error("reset done too early");
   mdc_need_a: assert property ($rose(reset_done) |-> mdc_seen)
      else $error("reset done without mdc edge");
   dark_early_a: assert property (!reset_done |->
      led_drive.enable == 5'h0)
      else $error("indicator driven before done");
   int_raise_a: assert property (reset_done && en_reg[0] &&
      phy_status.link_good != $past(phy_status.link_good) |=> !mgmt_int_oe)
      else $error("enabled event gave no interrupt");
   int_clear_a: assert property (st_rd && $stable(phy_status)
      |=> mgmt_int_oe)
      else $error("status read left interrupt on");
   int_hold_a: assert property (!mgmt_int_oe && !take
      |=> !mgmt_int_oe)
      else $error("interrupt dropped without read");
   int_quiet_a: assert property (mgmt_int_oe && !take &&
      $stable(phy_status) |=> mgmt_int_oe)
      else $error("interrupt without event");
   speed10_lit_a: assert property (lit_ok && phy_status.link_good &&
      !phy_status.speed_100 |=> led_drive.value[4] == !strap_reg[4])
      else $error("speed10 indicator not lit");
   speed100_lit_a: assert property (lit_ok &&
      phy_status.link_good && phy_status.speed_100
      |=> led_drive.value[0] == !strap_reg[0])
      else $error("speed100 indicator not lit");
   duplex_on_a: assert property (lit_ok && phy_status.full_duplex
      |=> led_drive.value[1] == !strap_reg[1]) else $error("duplex not lit");
   idle_dark_a: assert property (lit_ok && !phy_status.rx_active &&
      !phy_status.tx_active |=> led_drive.value[3] == strap_reg[3])
      else $error("activity lit while idle");
   link_off_a: assert property (lit_ok && !phy_status.link_good
      |=> led_drive.value[2] == strap_reg[2]) else $error("link lit, no link");
endmodule // led_checker
bind phy_led_strap_and_mgmt_interrupt led_checker u_chk (
   .core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .phy_status(phy_status), .mdc(mdc),
   .led_in(led_in), .led_drive(led_drive), .mgmt_int_out(mgmt_int_out),
   .mgmt_int_oe(mgmt_int_oe), .reset_done(reset_done));
`default_nettype wire

// ---- led_partner.sv ----
// Indicator LEDs with strap pulls and the pulled-up interrupt line.
`timescale 1ns/10ps
`default_nettype none
module led_partner
   import phy_led_pkg::*;
(
   input wire led_drive_t led_drive,
   input wire logic [4:0] pull,
   input wire logic mgmt_int_oe,
   input wire logic mgmt_int_out,
   output logic [4:0] led_in,
   output logic [4:0] lit,
   output logic int_line
);
   // An undriven pin rests at its pull; the LED sits against the pull rail,
   // so it lights only when the pin is driven to the opposite level.
   assign led_in = (led_drive.enable & led_drive.value) |
      (~led_drive.enable & pull);
   assign lit = led_drive.enable & (led_drive.value ^ pull);
   // Released open-drain line floats high through its pull-up.
   assign int_line = mgmt_int_oe ? mgmt_int_out : 1'b1;
endmodule // led_partner
`default_nettype wire

// ---- testbench.sv ----
// Register-level bench for the indicator, strap and interrupt block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import phy_led_pkg::*;
   localparam logic [4:0] PULL = 5'h16;
   logic core_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mdc;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic mgmt_int_out, mgmt_int_oe, reset_done, int_line;
   phy_status_t phy_status;
   led_drive_t led_drive;
   logic [4:0] led_in, lit;
   int fail_count = 0;
   int compares = 0;
   int hi, n;
   int fld[4] = '{4, 5, 3, 2};
   // Short counts keep the blink and settle phases within a brief run.
   phy_led_strap_and_mgmt_interrupt #(.SETTLE_CYCLES(8),
      .SLOW_HALF_CYCLES(4), .FAST_HALF_CYCLES(2)) u_dut (
      .core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .phy_status(phy_status), .mdc(mdc),
      .led_in(led_in), .led_drive(led_drive), .mgmt_int_out(mgmt_int_out),
      .mgmt_int_oe(mgmt_int_oe), .reset_done(reset_done));
   led_partner u_led (.led_drive(led_drive), .pull(PULL),
      .mgmt_int_oe(mgmt_int_oe), .mgmt_int_out(mgmt_int_out),
      .led_in(led_in), .lit(lit), .int_line(int_line));
   // Free-running core clock.
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic fail(input string m);
      fail_count++;
      $display("[ERR] %0t %s", $time, m);
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
   endtask
   // One classic cycle; the request stands until ack is seen high.
   task automatic wb(input logic we, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_sel_i <= 4'hf;
      wb_adr_i <= a;
      wb_dat_i <= d;
      // Only the watchdog ends a wait for the answer.
      do begin
         @(posedge core_clk);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      check(q, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   // Counts lit samples of one LED over four full slow periods.
   task automatic cnt(input int b);
      hi = 0;
      repeat (3) @(posedge core_clk);
      repeat (32) begin
         @(posedge core_clk);
         hi += (lit[b] === 1'b1);
      end
   endtask
   task automatic close_out;
      $display("mismatches %0d compares %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Cuts a hang short well beyond the expected run of a few hundred cycles.
   initial begin
      repeat (4000) @(posedge core_clk);
      fail("watchdog");
      close_out;
   end
   initial begin
      reset_n = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h0;
      wb_sel_i = 4'hf;
      wb_dat_i = 32'h0;
      mdc = 1'b0;
      phy_status = '0;
      repeat (2) @(posedge core_clk);
      check(lit, 5'h0);
      reset_n <= 1'b1;
      repeat (20) @(posedge core_clk);
      check(reset_done, 1'b0);
      mdc <= 1'b1;
      n = 0;
      while (reset_done !== 1'b1 && n < 50) begin
         @(posedge core_clk);
         n++;
      end
      check(reset_done, 1'b1);
      rd(8'h50, {24'h0, PULL, 3'h0});
      wr(8'h50, 32'h0);
      rd(8'h50, {24'h0, PULL, 3'h0});
      rd(8'h04, 32'h0);
      rd(8'h6c, 32'h0);
      rd(8'h60, 32'h0);
      wr(8'h60, 32'hf);
      rd(8'h60, 32'hf);
      // Each event kind in turn raises the line, and the read clears it.
      for (int i = 0; i < 4; i++) begin
         phy_status[fld[i]] <= 1'b1;
         repeat (3) @(posedge core_clk);
         check(int_line, 1'b1);
         rd(8'h5c, 32'h1 << i);
         check(int_line, 1'b0);
      end
      wr(8'h60, 32'he);
      phy_status.link_good <= 1'b0;
      repeat (3) @(posedge core_clk);
      check(int_line, 1'b0);
      rd(8'h5c, 32'h1);
      phy_status <= 6'b110000;
      repeat (3) @(posedge core_clk);
      check(lit, 5'h05);
      phy_status <= 6'b010000;
      repeat (3) @(posedge core_clk);
      check(lit, 5'h14);
      phy_status <= 6'b011000;
      cnt(1);
      check(hi, 32);
      phy_status <= 6'b010100;
      cnt(1);
      check(hi, 16);
      phy_status <= 6'b010010;
      cnt(3);
      check(hi, 16);
      cnt(2);
      check(hi, 16);
      wr(8'h6c, 32'h200);
      rd(8'h6c, 32'h200);
      cnt(2);
      check(hi, 32);
      phy_status <= 6'b010001;
      cnt(3);
      check(hi, 16);
      // Reset again with the management clock resting high, so only a
      // real transition after release may complete it.
      reset_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      check(lit, 5'h0);
      check(reset_done, 1'b0);
      reset_n <= 1'b1;
      repeat (20) @(posedge core_clk);
      check(reset_done, 1'b0);
      mdc <= 1'b0;
      repeat (6) @(posedge core_clk);
      check(reset_done, 1'b1);
      rd(8'h50, {24'h0, PULL, 3'h0});
      close_out;
   end
endmodule // testbench
`default_nettype wire
